// *** src/dsp_pkg.sv ***
// Functional notes
// [RQ1] Narrow port has 8-bit write-only direction register
// [RQ2] Narrow direction loads H'E0 on reset/hardware standby
// [RQ3] Software standby keeps every register unchanged
// [RQ4] Narrow output pins keep driving in software standby
// [RQ5] Narrow read: data bit if output, else pin
// [RQ6] Narrow data bits 7..5 fixed, read 1
// [RQ7] Narrow bits 4..2 pinless storage, 1 when input
// [RQ8] Narrow data loads H'E0 on reset/hardware standby
// [RQ9] Narrow pins always feed interrupt requests 1, 0
// [RQ10] Upper narrow pin output only in modes 6, 7
// [RQ11] Wide pin output when direction bit is 1
// [RQ12] Wide direction write-only, reads all ones
// [RQ13] Wide direction bits 5..0 pins, resets H'C0
// [RQ14] Wide output pins keep driving in software standby
// [RQ15] Wide read: data bit if output, else pin
// [RQ16] Wide data bits 7, 6 fixed, read 1
// [RQ17] Wide data loads H'C0 on reset/hardware standby
// [RQ18] Wide port behaves identically in every mode
// [RQ19] Wide pins shared with serial and interrupts 5, 4
// [RQ20] Narrow direction bits 1, 0 pins, reads ones
//
// Constants, register map and carrier types of the dual small port.
// Assumes a 40 MHz system clock and an Avalon-MM master with byte addressing.
package dsp_pkg;

	localparam int DATA_W = 8;
	localparam int NARROW_PINS = 2;
	localparam int WIDE_PINS = 6;

	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_NARROW_DIRECTION = 16'hFFCD;
	localparam logic [15:0] IDX_NARROW_DATA = 16'hFFCF;
	localparam logic [15:0] IDX_WIDE_DIRECTION = 16'hFFD0;
	localparam logic [15:0] IDX_WIDE_DATA = 16'hFFD2;
	localparam int IDX_SHIFT = 2;

	// Reset values and bit classes
	localparam logic [7:0] NARROW_RESET = 8'hE0;
	localparam logic [7:0] WIDE_RESET = 8'hC0;
	localparam logic [7:0] NARROW_STORE_MASK = 8'h1F;
	localparam logic [7:0] NARROW_PIN_MASK = 8'h03;
	localparam logic [7:0] WIDE_STORE_MASK = 8'h3F;
	localparam logic [7:0] WIDE_PIN_MASK = 8'h3F;
	localparam logic [7:0] WRITE_ONLY_READ = 8'hFF;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

	// Pin positions
	localparam int NARROW_UPPER_PIN = 1;
	localparam int WIDE_TXD_A = 0;
	localparam int WIDE_TXD_B = 1;
	localparam int WIDE_RXD_A = 2;
	localparam int WIDE_RXD_B = 3;
	localparam int WIDE_CLK_A = 4;
	localparam int WIDE_CLK_B = 5;

	// Operating modes
	localparam logic [2:0] MODE_SINGLE_6 = 3'h6;
	localparam logic [2:0] MODE_SINGLE_7 = 3'h7;

	// Bus answer sequencing
	typedef enum logic [0:0] {
		DSP_BUS_IDLE   = 1'b0,
		DSP_BUS_ANSWER = 1'b1
	} dsp_bus_state_t;

	// Drive of a pin group
	typedef struct packed {
		logic [WIDE_PINS-1:0] oe;
		logic [WIDE_PINS-1:0] dat;
	} dsp_wide_drive_t;

	typedef struct packed {
		logic [NARROW_PINS-1:0] oe;
		logic [NARROW_PINS-1:0] dat;
	} dsp_narrow_drive_t;

	// Pin levels handed to the serial channels
	typedef struct packed {
		logic rxd_a;
		logic rxd_b;
		logic clk_a;
		logic clk_b;
	} dsp_serial_sense_t;

	// External interrupt request levels
	typedef struct packed {
		logic req_5;
		logic req_4;
		logic req_1;
		logic req_0;
	} dsp_irq_t;

endpackage

// *** src/dsp_port_bank.sv ***
// One port: direction and data registers with the mixed read path.
// Assumes the parent qualifies writes and supplies pins padded to 8 bits.
module dsp_port_bank #(
	parameter logic [7:0] RESET_VAL  = 8'hE0,
	parameter logic [7:0] STORE_MASK = 8'h1F,
	parameter logic [7:0] PIN_MASK   = 8'h03
) (
	input  wire logic       clock_i,
	input  wire logic       rstn_i,
	input  wire logic       hw_standby_i,
	input  wire logic       hold_i,
	input  wire logic       wr_dir_i,
	input  wire logic       wr_dat_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic [7:0] pin_i,
	output logic      [7:0] dir_o,
	output logic      [7:0] dat_o,
	output logic      [7:0] read_o
);

	logic [7:0] dir_reg;
	logic [7:0] dir_next;
	logic [7:0] dat_reg;
	logic [7:0] dat_next;

	// Fixed bits stay one; only storable bits take write data
	function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v);
		merge = (old_v & ~STORE_MASK) | (new_v & STORE_MASK);
	endfunction

	// Software standby holds: writes blocked, nothing reloaded
	assign dir_next = (wr_dir_i && !hold_i) ? merge(dir_reg, wdata_i) : dir_reg; // RQ3
	assign dat_next = (wr_dat_i && !hold_i) ? merge(dat_reg, wdata_i) : dat_reg; // RQ3

	// Hardware standby acts as a synchronous reload of reset values
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dir_reg <= RESET_VAL; // RQ2
			dat_reg <= RESET_VAL; // RQ8
		end else if (hw_standby_i) begin
			dir_reg <= RESET_VAL; // RQ13
			dat_reg <= RESET_VAL; // RQ17
		end else begin
			dir_reg <= dir_next;
			dat_reg <= dat_next;
		end
	end

	// Output bits show data, inputs show pin, pinless inputs show one
	assign read_o = ~STORE_MASK
		| (STORE_MASK & dir_reg & dat_reg) // RQ5
		| (STORE_MASK & ~dir_reg & PIN_MASK & pin_i) // RQ15
		| (STORE_MASK & ~dir_reg & ~PIN_MASK); // RQ7
	assign dir_o = dir_reg;
	assign dat_o = dat_reg;

endmodule

// *** src/dsp_port_top.sv ***
// Dual small pin port: a two-pin port and a six-pin port behind Avalon-MM.
// Assumes pins are synchronous to clock_i and the master holds requests
// until waitrequest is low. Serial pin selection is decided elsewhere and
// arrives here as a peripheral drive request per wide pin.
//
// The Avalon-MM register port is this design's own decision.
module dsp_port_top #(
	parameter int ADDR_W = 18
) (
	input  wire logic                       clock_i,
	input  wire logic                       rstn_i,
	// Standby and operating mode
	input  wire logic                       hw_standby_i,
	input  wire logic                       sw_standby_i,
	input  wire logic [2:0]                 mode_i,
	// Avalon-MM slave
	input  wire logic [ADDR_W-1:0]          avs_address_i,
	input  wire logic                       avs_read_i,
	input  wire logic                       avs_write_i,
	input  wire logic [3:0]                 avs_byteenable_i,
	input  wire logic [31:0]                avs_writedata_i,
	output logic      [31:0]                avs_readdata_o,
	output logic                            avs_waitrequest_o,
	// Narrow port pins
	input  wire logic [1:0]                 narrow_pin_i,
	output logic      [1:0]                 narrow_pin_o,
	output logic      [1:0]                 narrow_pin_oe_o,
	// Wide port pins
	input  wire logic [5:0]                 wide_pin_i,
	output logic      [5:0]                 wide_pin_o,
	output logic      [5:0]                 wide_pin_oe_o,
	// Serial channel sharing of the wide pins
	input  dsp_pkg::dsp_wide_drive_t        periph_drive_i,
	output dsp_pkg::dsp_serial_sense_t      serial_sense_o,
	// Interrupt request levels and mode misuse flag
	output dsp_pkg::dsp_irq_t               irq_o,
	output logic                            illegal_setting_o
);

	// Address decode
	logic [ADDR_W-1:0] addr_narrow_dir;
	logic [ADDR_W-1:0] addr_narrow_dat;
	logic [ADDR_W-1:0] addr_wide_dir;
	logic [ADDR_W-1:0] addr_wide_dat;
	logic              hit_narrow_dir;
	logic              hit_narrow_dat;
	logic              hit_wide_dir;
	logic              hit_wide_dat;
	logic              lane0;

	// Bus sequencing
	dsp_pkg::dsp_bus_state_t bus_state_reg;
	dsp_pkg::dsp_bus_state_t bus_state_next;
	logic                    req;
	logic                    take;
	logic                    wr_take;
	logic [31:0]             readdata_reg;
	logic [31:0]             readdata_next;
	logic [31:0]             read_mux;

	// Port bank wiring
	logic [7:0] narrow_pin_pad;
	logic [7:0] wide_pin_pad;
	logic [7:0] narrow_dir;
	logic [7:0] narrow_dat;
	logic [7:0] narrow_read;
	logic [7:0] wide_dir;
	logic [7:0] wide_dat;
	logic [7:0] wide_read;

	// Mode handling
	logic [2:0] mode_reg;
	logic       mode_taken_reg;
	logic       single_chip;
	logic       upper_gate;

	// Pin drive
	logic [1:0] narrow_oe;
	logic [5:0] wide_own_oe;
	logic [5:0] wide_oe;
	logic [5:0] wide_out;

	// Byte address of a register from its index
	function automatic logic [ADDR_W-1:0] reg_addr(input logic [15:0] idx);
		logic [ADDR_W-1:0] wide_idx;
		wide_idx = ADDR_W'(idx);
		reg_addr = ADDR_W'(wide_idx << dsp_pkg::IDX_SHIFT);
	endfunction

	// Places an 8-bit register value in the low lane of a bus word
	function automatic logic [31:0] low_lane(input logic [7:0] v);
		low_lane = {24'h00_0000, v};
	endfunction

	// Register addresses
	assign addr_narrow_dir = reg_addr(dsp_pkg::IDX_NARROW_DIRECTION);
	assign addr_narrow_dat = reg_addr(dsp_pkg::IDX_NARROW_DATA);
	assign addr_wide_dir   = reg_addr(dsp_pkg::IDX_WIDE_DIRECTION);
	assign addr_wide_dat   = reg_addr(dsp_pkg::IDX_WIDE_DATA);

	// Full decode; anything else is unmapped
	assign hit_narrow_dir = (avs_address_i == addr_narrow_dir);
	assign hit_narrow_dat = (avs_address_i == addr_narrow_dat);
	assign hit_wide_dir   = (avs_address_i == addr_wide_dir);
	assign hit_wide_dat   = (avs_address_i == addr_wide_dat);
	assign lane0          = avs_byteenable_i[0];

	// Request presence; read and write together are treated as no request
	assign req = avs_read_i ^ avs_write_i;

	// One wait cycle per access keeps read data registered
	always_comb begin
		bus_state_next = bus_state_reg;
		unique case (bus_state_reg)
			dsp_pkg::DSP_BUS_IDLE: begin
				if (req) begin
					bus_state_next = dsp_pkg::DSP_BUS_ANSWER;
				end
			end
			dsp_pkg::DSP_BUS_ANSWER: begin
				bus_state_next = dsp_pkg::DSP_BUS_IDLE;
			end
		endcase
	end

	// The access completes at the edge where waitrequest is low
	assign take              = req && (bus_state_reg == dsp_pkg::DSP_BUS_ANSWER);
	assign avs_waitrequest_o = req && (bus_state_reg == dsp_pkg::DSP_BUS_IDLE);
	assign wr_take           = take && avs_write_i && lane0;

	// Read selection; write-only registers answer all ones
	assign read_mux =
		hit_narrow_dir ? low_lane(dsp_pkg::WRITE_ONLY_READ) : // RQ20
		hit_narrow_dat ? low_lane(narrow_read) : // RQ5
		hit_wide_dir   ? low_lane(dsp_pkg::WRITE_ONLY_READ) : // RQ12
		hit_wide_dat   ? low_lane(wide_read) : // RQ15
		dsp_pkg::UNMAPPED_READ;

	// Read data sampled in the wait cycle, shown while waitrequest is low
	assign readdata_next = (req && avs_read_i && bus_state_reg == dsp_pkg::DSP_BUS_IDLE)
		? read_mux : readdata_reg;

	// Bus state and read data
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bus_state_reg <= dsp_pkg::DSP_BUS_IDLE;
			readdata_reg  <= dsp_pkg::UNMAPPED_READ;
		end else begin
			bus_state_reg <= bus_state_next;
			readdata_reg  <= readdata_next;
		end
	end

	assign avs_readdata_o = readdata_reg;

	// Mode straps caught on the first edge after reset release
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_reg       <= dsp_pkg::MODE_SINGLE_7;
			mode_taken_reg <= 1'b0;
		end else if (!mode_taken_reg) begin
			mode_reg       <= mode_i;
			mode_taken_reg <= 1'b1;
		end
	end

	// Only single-chip modes let the upper narrow pin drive
	assign single_chip = (mode_reg == dsp_pkg::MODE_SINGLE_6)
		|| (mode_reg == dsp_pkg::MODE_SINGLE_7); // RQ10
	assign upper_gate  = single_chip;

	// Pins padded to register width for the banks
	assign narrow_pin_pad = {6'h00, narrow_pin_i};
	assign wide_pin_pad   = {2'h0, wide_pin_i};

	// Narrow port registers
	dsp_port_bank #(
		.RESET_VAL  (dsp_pkg::NARROW_RESET),
		.STORE_MASK (dsp_pkg::NARROW_STORE_MASK),
		.PIN_MASK   (dsp_pkg::NARROW_PIN_MASK)
	) u_narrow (
		.clock_i      (clock_i),
		.rstn_i       (rstn_i),
		.hw_standby_i (hw_standby_i),
		.hold_i       (sw_standby_i),
		.wr_dir_i     (wr_take && hit_narrow_dir), // RQ1
		.wr_dat_i     (wr_take && hit_narrow_dat), // RQ6
		.wdata_i      (avs_writedata_i[7:0]),
		.pin_i        (narrow_pin_pad),
		.dir_o        (narrow_dir),
		.dat_o        (narrow_dat),
		.read_o       (narrow_read)
	);

	// Wide port registers
	dsp_port_bank #(
		.RESET_VAL  (dsp_pkg::WIDE_RESET),
		.STORE_MASK (dsp_pkg::WIDE_STORE_MASK),
		.PIN_MASK   (dsp_pkg::WIDE_PIN_MASK)
	) u_wide (
		.clock_i      (clock_i),
		.rstn_i       (rstn_i),
		.hw_standby_i (hw_standby_i),
		.hold_i       (sw_standby_i),
		.wr_dir_i     (wr_take && hit_wide_dir), // RQ13
		.wr_dat_i     (wr_take && hit_wide_dat), // RQ16
		.wdata_i      (avs_writedata_i[7:0]),
		.pin_i        (wide_pin_pad),
		.dir_o        (wide_dir),
		.dat_o        (wide_dat),
		.read_o       (wide_read)
	);

	// Narrow drive ignores software standby so outputs hold their state
	assign narrow_oe[0] = narrow_dir[0]; // RQ4
	assign narrow_oe[dsp_pkg::NARROW_UPPER_PIN] =
		narrow_dir[dsp_pkg::NARROW_UPPER_PIN] && upper_gate; // RQ10
	assign narrow_pin_oe_o = narrow_oe;
	assign narrow_pin_o    = narrow_dat[1:0];

	// A set upper direction bit outside single-chip modes is flagged
	assign illegal_setting_o = narrow_dir[dsp_pkg::NARROW_UPPER_PIN] && !upper_gate; // RQ10

	// Wide drive is mode independent; serial function overrides per pin
	assign wide_own_oe = wide_dir[5:0]; // RQ11
	assign wide_oe  = periph_drive_i.oe | wide_own_oe; // RQ19
	assign wide_out = (periph_drive_i.oe & periph_drive_i.dat)
		| (~periph_drive_i.oe & wide_dat[5:0]); // RQ14
	assign wide_pin_oe_o = wide_oe; // RQ18
	assign wide_pin_o    = wide_out;

	// Serial lines see raw pin levels whatever the direction
	assign serial_sense_o.rxd_a = wide_pin_i[dsp_pkg::WIDE_RXD_A]; // RQ19
	assign serial_sense_o.rxd_b = wide_pin_i[dsp_pkg::WIDE_RXD_B];
	assign serial_sense_o.clk_a = wide_pin_i[dsp_pkg::WIDE_CLK_A];
	assign serial_sense_o.clk_b = wide_pin_i[dsp_pkg::WIDE_CLK_B];

	// Interrupt logic always sees the pin, driven or not
	assign irq_o.req_0 = narrow_pin_i[0]; // RQ9
	assign irq_o.req_1 = narrow_pin_i[dsp_pkg::NARROW_UPPER_PIN]; // RQ9
	assign irq_o.req_4 = wide_pin_i[dsp_pkg::WIDE_CLK_A]; // RQ19
	assign irq_o.req_5 = wide_pin_i[dsp_pkg::WIDE_CLK_B]; // RQ19

endmodule

// *** tb/dsp_pad_model.sv ***
// Pad model of one pin group.
// Assumes the bench changes the outside level between accesses.
module dsp_pad_model #(
	parameter int W = 6
) (
	input  wire logic [W-1:0] oe_i,
	input  wire logic [W-1:0] drv_i,
	input  wire logic [W-1:0] ext_i,
	output logic      [W-1:0] pad_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// No pulls here, so an undriven pad follows the outside source
	assign pad_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule

// *** tb/dsp_port_checker.sv ***
// Checker of pad, bus and standby relations of the dual port.
// Assumes mode_i is steady between resets.
module dsp_port_checker #(
	parameter int ADDR_W = 18
) (
	input wire logic                  clock_i,
	input wire logic                  rstn_i,
	input wire logic                  hw_standby_i,
	input wire logic                  sw_standby_i,
	input wire logic [2:0]            mode_i,
	input wire logic [ADDR_W-1:0]     avs_address_i,
	input wire logic                  avs_read_i,
	input wire logic                  avs_write_i,
	input wire logic [3:0]            avs_byteenable_i,
	input wire logic [31:0]           avs_writedata_i,
	input wire logic [31:0]           avs_readdata_o,
	input wire logic                  avs_waitrequest_o,
	input wire logic [1:0]            narrow_pin_i,
	input wire logic [1:0]            narrow_pin_o,
	input wire logic [1:0]            narrow_pin_oe_o,
	input wire logic [5:0]            wide_pin_i,
	input wire logic [5:0]            wide_pin_o,
	input wire logic [5:0]            wide_pin_oe_o,
	input dsp_pkg::dsp_wide_drive_t   periph_drive_i,
	input dsp_pkg::dsp_serial_sense_t serial_sense_o,
	input dsp_pkg::dsp_irq_t          irq_o,
	input wire logic                  illegal_setting_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!rstn_i);
	// Completed read and its target
	wire rd_end = avs_read_i && !avs_write_i && !avs_waitrequest_o;
	wire at_nq  = avs_address_i == 18'h3FF3C;
	wire at_wq  = avs_address_i == 18'h3FF48;
	wire at_dir = avs_address_i == 18'h3FF34 || avs_address_i == 18'h3FF40;

	a_irq_level: assert property (irq_o == {wide_pin_i[5:4], narrow_pin_i})
		else $error("irq level differs from pins");
	a_dir_ones: assert property (rd_end && at_dir |-> avs_readdata_o == 32'h0000_00FF)
		else $error("direction read not all ones");
	a_narrow_fixed: assert property (rd_end && at_nq |-> &avs_readdata_o[7:5])
		else $error("narrow fixed bits not one");
	a_wide_fixed: assert property (rd_end && at_wq |-> &avs_readdata_o[7:6])
		else $error("wide fixed bits not one");
	a_narrow_read: assert property (rd_end && at_nq |->
		((avs_readdata_o[1:0] ^ narrow_pin_o) & narrow_pin_oe_o) == 2'h0)
		else $error("narrow output bit read wrong");
	a_wide_read: assert property (rd_end && at_wq |->
		((avs_readdata_o[5:0] ^ wide_pin_o) & wide_pin_oe_o & ~periph_drive_i.oe) == 6'h0)
		else $error("wide output bit read wrong");
	a_upper_mode: assert property (narrow_pin_oe_o[1] |->
		mode_i[2:1] == 2'h3 && !illegal_setting_o)
		else $error("upper narrow pin driven in bus mode");
	a_hw_reload: assert property (hw_standby_i |=> {narrow_pin_oe_o, narrow_pin_o} == 4'h0)
		else $error("narrow pins not reloaded");
	a_sw_hold: assert property (sw_standby_i && !hw_standby_i |=>
		$stable({narrow_pin_oe_o, narrow_pin_o}))
		else $error("narrow pins moved in standby");
endmodule

// *** tb/dsp_port_tb_top.sv ***
// Bench of the dual small port: random traffic, standby, unmapped place.
// Assumes the pad model and checker are compiled first.
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
	$display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module dsp_port_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                       clk   = 1'b0;
	logic                       rstn  = 1'b0;
	logic                       hws   = 1'b0;
	logic                       sws   = 1'b0;
	logic                       rd    = 1'b0;
	logic                       wr    = 1'b0;
	logic [2:0]                 mode  = 3'h7;
	logic [17:0]                addr  = 18'h0;
	logic [31:0]                wdat  = 32'h0;
	logic [31:0]                seed  = 32'h0001_7CD3;
	logic [1:0]                 n_ext = 2'h0;
	logic [5:0]                 w_ext = 6'h0;
	dsp_pkg::dsp_wide_drive_t   pdrv  = '0;
	logic                       wt, ill;
	logic [31:0]                rdat, q;
	logic [1:0]                 npin, npo, npoe;
	logic [5:0]                 wpin, wpo, wpoe;
	dsp_pkg::dsp_irq_t          irq;
	dsp_pkg::dsp_serial_sense_t sen;
	logic [3:0]                 be    = 4'h1;
	// Expected contents, fixed ones and byte addresses
	logic [7:0]                 ev [4];
	logic [7:0]                 fx [4] = '{8'hE0, 8'hE0, 8'hC0, 8'hC0};
	logic [17:0]                am [4] = '{18'h3FF34, 18'h3FF3C, 18'h3FF40, 18'h3FF48};
	int                         err_total = 0;
	int                         check_count = 0;

	initial begin
		forever #12.5 clk = ~clk;
	end

	dsp_port_top u_dut (.clock_i(clk), .rstn_i(rstn), .hw_standby_i(hws), .sw_standby_i(sws),
		.mode_i(mode), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_byteenable_i(be), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wt), .narrow_pin_i(npin), .narrow_pin_o(npo),
		.narrow_pin_oe_o(npoe), .wide_pin_i(wpin), .wide_pin_o(wpo), .wide_pin_oe_o(wpoe),
		.periph_drive_i(pdrv), .serial_sense_o(sen), .irq_o(irq), .illegal_setting_o(ill));
	dsp_pad_model #(.W(2)) u_npad (.oe_i(npoe), .drv_i(npo), .ext_i(n_ext), .pad_o(npin));
	dsp_pad_model #(.W(6)) u_wpad (.oe_i(wpoe), .drv_i(wpo), .ext_i(w_ext), .pad_o(wpin));

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Read value: fixed ones, data where output, pin or one where input
	function automatic logic [7:0] expv(input logic [7:0] d, r, p, s, m);
		return ~s | (s & ((d & r) | (~d & p & m) | (~d & ~m)));
	endfunction

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// One Avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [17:0] a, input logic [7:0] d);
		int n = 0;
		@(posedge clk);
		addr <= a;
		wdat <= {24'h0, d};
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (wt !== 1'b0 && n < 64);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		if (n >= 64) begin
			err_total++;
			print_verdict();
		end
	endtask

	task automatic wreg(input int k, input logic [7:0] d);
		bus(1'b1, am[k], d);
		if (!sws) ev[k] = d | fx[k];
	endtask

	task automatic chk_all();
		bus(1'b0, am[1], 8'h0);
		`CHK(q, {24'h0, expv(ev[0], ev[1], {6'h0, npin}, 8'h1F, 8'h03)})
		bus(1'b0, am[3], 8'h0);
		`CHK(q, {24'h0, expv(ev[2], ev[3], {2'h0, wpin}, 8'h3F, 8'h3F)})
		for (int k = 0; k < 4; k += 2) begin
			bus(1'b0, am[k], 8'h0);
			`CHK(q, 32'h0000_00FF)
		end
		`CHK(npoe, ev[0][1:0] & {mode[2:1] == 2'h3, 1'b1})
		`CHK(npo & npoe, ev[1][1:0] & npoe)
		`CHK(ill, ev[0][1] & (mode[2:1] != 2'h3))
		`CHK(wpoe, ev[2][5:0] | pdrv.oe)
		`CHK(wpo & wpoe, ((ev[3][5:0] & ~pdrv.oe) | (pdrv.dat & pdrv.oe)) & wpoe)
		`CHK(irq, {wpin[5:4], npin})
		`CHK(sen, {wpin[2], wpin[3], wpin[4], wpin[5]})
	endtask

	task automatic rnd(input int n);
		logic [31:0] r;
		for (int i = 0; i < n; i++) begin
			r = xs();
			n_ext <= r[1:0];
			w_ext <= r[7:2];
			pdrv <= r[19:8];
			wreg(int'(r[21:20]), r[31:24]);
			chk_all();
		end
	endtask

	task automatic do_reset(input logic [2:0] m);
		rstn <= 1'b0;
		mode <= m;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		ev = fx;
	endtask

	initial begin
		do_reset(3'h7);
		chk_all();
		for (int k = 0; k < 4; k++) wreg(k, 8'hFF);
		chk_all();
		rnd(40);
		// Software standby drops writes, pads keep driving
		sws <= 1'b1;
		for (int k = 0; k < 4; k++) wreg(k, 8'h15);
		chk_all();
		sws <= 1'b0;
		// Hardware standby reloads every register
		hws <= 1'b1;
		repeat (2) @(posedge clk);
		hws <= 1'b0;
		ev = fx;
		chk_all();
		// Unmapped place reads zero and takes no write
		bus(1'b1, 18'h3FF38, 8'h5A);
		bus(1'b0, 18'h3FF38, 8'h00);
		`CHK(q, 32'h0)
		// Lane 0 disabled: write completes but leaves the register alone
		be <= 4'h0;
		bus(1'b1, am[3], 8'h2A);
		be <= 4'h1;
		chk_all();
		// External-bus mode keeps the upper narrow pin an input
		do_reset(3'h3);
		wreg(0, 8'h03);
		chk_all();
		rnd(10);
		print_verdict();
	end
endmodule

bind dsp_port_top dsp_port_checker #(.ADDR_W(ADDR_W)) u_chk (.*);
